// ==== logic/bbt_pkg.sv ====
// Package of constants for the Billboard detach timer B block.
`default_nettype none
package bbt_pkg;
    localparam logic [15:0] ADDR_TMR_LO = 16'h413e;
    localparam logic [15:0] ADDR_TMR_HI = 16'h413f;
    localparam logic [15:0] ADDR_CTRL = 16'h4180;
    localparam logic [15:0] ADDR_STAT = 16'h4181;
    localparam logic [15:0] ADDR_DESC_BASE = 16'h4140;
    localparam int DESC_LEN = 48;
    localparam logic [7:0] TMR_LO_RST = 8'hd0;
    localparam logic [7:0] TMR_HI_RST = 8'h07;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int DET_MS = 1;
    localparam int DET_CYC = CLK_HZ / 1000 * DET_MS;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_BB_BIT = 1;
    localparam int STAT_DET_BIT = 2;
    localparam int CTRL_EN_BIT = 0;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam int IDX_NUM_ALT = 4;
    localparam int IDX_VCONN1 = 7;
    localparam int IDX_URL = 3;
    localparam int IDX_VER0 = 40;
    localparam int IDX_VER1 = 41;
    localparam int IDX_SVID1 = 45;
    localparam logic [7:0] DEF_NUM_ALT = 8'h01;
    localparam logic [7:0] DEF_VCONN1 = 8'h80;
    localparam logic [7:0] DEF_URL = 8'h01;
    localparam logic [7:0] DEF_VER0 = 8'h10;
    localparam logic [7:0] DEF_VER1 = 8'h01;
    localparam logic [7:0] DEF_SVID1 = 8'hff;
    typedef enum logic [3:0] {
        BBT_BILLBOARD = 4'b0001,
        BBT_RUNNING = 4'b0010,
        BBT_DETACH = 4'b0100,
        BBT_VENDOR = 4'b1000
    } bbt_state_t;
endpackage
`default_nettype wire

// ==== logic/bbt_top.sv ====
// Detach timer B and configurable descriptor store of the internal Billboard function.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (R01) Timer B starts counting when the host requests the alternate-mode string.
// (R02) When timer B elapses the function detaches by itself and comes back as vendor device.
// (R03) The timeout counts in 10 ms steps and its high byte lives at the upper timer offset.
// (R04) The timeout defaults to 2000 counts, which is twenty seconds.
// (R05) The alternate-mode string and additional-info URL contents are configurable.
// (R06) Capability fields default to one mode, preferred zero, zero status, version 1.10, id 00h FFh.
// (R07) The alternate-mode string is served while connected in Billboard mode; a request in the idle state starts the timer if the enable bit is set.
// (R08) After the forced detach the function reconnects with its standard descriptors.
module bbt_top #(
    parameter int TICK_CYCLES = bbt_pkg::TICK_CYC,
    parameter int DETACH_CYCLES = bbt_pkg::DET_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic alt_string_req,
    output logic alt_string_ack,
    output logic func_connect,
    output logic billboard_mode
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        bbt_pkg::bbt_state_t state;
        logic [7:0] tmr_lo;
        logic [7:0] tmr_hi;
        logic [7:0] ctrl;
        logic [15:0] remain;
        logic [23:0] tick;
        logic [23:0] det;
        logic [7:0] rdata;
        logic ack;
        logic conn;
        logic bb;
    } bbt_regs_t;

    bbt_regs_t r;
    bbt_regs_t next_r;
    logic [7:0] desc [bbt_pkg::DESC_LEN];
    logic [7:0] desc_rd;
    logic desc_hit;
    logic [15:0] desc_off;

    assign desc_off = reg_addr - bbt_pkg::ADDR_DESC_BASE;
    assign desc_hit = (reg_addr >= bbt_pkg::ADDR_DESC_BASE) &&
                      (desc_off < 16'(bbt_pkg::DESC_LEN));

    ////////////////////////////////////////////////////////////////////////////////
    // Descriptor bytes sit in a plain array so software can rewrite them before enumeration.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < bbt_pkg::DESC_LEN; i++) begin
                desc[i] <= 8'h00; // R06
            end
            desc[bbt_pkg::IDX_NUM_ALT] <= bbt_pkg::DEF_NUM_ALT; // R06
            desc[bbt_pkg::IDX_VCONN1] <= bbt_pkg::DEF_VCONN1;
            desc[bbt_pkg::IDX_URL] <= bbt_pkg::DEF_URL;
            desc[bbt_pkg::IDX_VER0] <= bbt_pkg::DEF_VER0; // R06
            desc[bbt_pkg::IDX_VER1] <= bbt_pkg::DEF_VER1;
            desc[bbt_pkg::IDX_SVID1] <= bbt_pkg::DEF_SVID1; // R06
        end else if (reg_wr && desc_hit) begin
            desc[desc_off[5:0]] <= reg_wdata; // R05
        end
    end

    assign desc_rd = desc[desc_off[5:0]];

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.ack = 1'b0;
        next_r.rdata = 8'h00;
        if (reg_wr) begin
            if (reg_addr == bbt_pkg::ADDR_TMR_LO) begin
                next_r.tmr_lo = reg_wdata;
            end else if (reg_addr == bbt_pkg::ADDR_TMR_HI) begin
                next_r.tmr_hi = reg_wdata; // R03
            end else if (reg_addr == bbt_pkg::ADDR_CTRL) begin
                next_r.ctrl = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == bbt_pkg::ADDR_TMR_LO) begin
                next_r.rdata = r.tmr_lo;
            end else if (reg_addr == bbt_pkg::ADDR_TMR_HI) begin
                next_r.rdata = r.tmr_hi;
            end else if (reg_addr == bbt_pkg::ADDR_CTRL) begin
                next_r.rdata = r.ctrl;
            end else if (reg_addr == bbt_pkg::ADDR_STAT) begin
                next_r.rdata[bbt_pkg::STAT_RUN_BIT] = (r.state == bbt_pkg::BBT_RUNNING);
                next_r.rdata[bbt_pkg::STAT_BB_BIT] = r.bb;
                next_r.rdata[bbt_pkg::STAT_DET_BIT] = (r.state == bbt_pkg::BBT_DETACH);
            end else if (desc_hit) begin
                next_r.rdata = desc_rd;
            end
        end
        // The string is answered in Billboard mode while connected, including while the timer runs, but not during the detach.
        if (alt_string_req && r.bb && r.conn) begin
            next_r.ack = 1'b1; // R07
        end
        case (r.state)
            bbt_pkg::BBT_BILLBOARD: begin
                if (alt_string_req && r.ctrl[bbt_pkg::CTRL_EN_BIT]) begin
                    next_r.state = bbt_pkg::BBT_RUNNING; // R01
                    next_r.remain = {r.tmr_hi, r.tmr_lo};
                    next_r.tick = 24'h000000;
                end
            end
            bbt_pkg::BBT_RUNNING: begin
                // Repeated requests do not restart; the first one sets the deadline.
                if (r.remain == 16'h0000) begin
                    next_r.state = bbt_pkg::BBT_DETACH; // R02
                    next_r.conn = 1'b0;
                    next_r.det = 24'h000000;
                end else if (r.tick == 24'(TICK_CYCLES - 1)) begin
                    next_r.tick = 24'h000000;
                    next_r.remain = r.remain - 16'h0001; // R03
                end else begin
                    next_r.tick = r.tick + 24'h000001;
                end
            end
            bbt_pkg::BBT_DETACH: begin
                if (r.det == 24'(DETACH_CYCLES - 1)) begin
                    next_r.state = bbt_pkg::BBT_VENDOR; // R08
                    next_r.conn = 1'b1;
                    next_r.bb = 1'b0;
                end else begin
                    next_r.det = r.det + 24'h000001;
                end
            end
            bbt_pkg::BBT_VENDOR: begin
                next_r.bb = 1'b0; // R08
            end
            default: begin
                next_r.state = bbt_pkg::BBT_BILLBOARD;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r.state <= bbt_pkg::BBT_BILLBOARD;
            r.tmr_lo <= bbt_pkg::TMR_LO_RST; // R04
            r.tmr_hi <= bbt_pkg::TMR_HI_RST; // R04
            r.ctrl <= bbt_pkg::CTRL_RST;
            r.remain <= 16'h0000;
            r.tick <= 24'h000000;
            r.det <= 24'h000000;
            r.rdata <= 8'h00;
            r.ack <= 1'b0;
            r.conn <= 1'b1;
            r.bb <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign alt_string_ack = r.ack;
    assign func_connect = r.conn;
    assign billboard_mode = r.bb;

    ////////////////////////////////////////////////////////////////////////////////
    property p_start;
        @(posedge clk_sys) disable iff (!rst_n)
        (r.state == bbt_pkg::BBT_BILLBOARD && alt_string_req && r.ctrl[bbt_pkg::CTRL_EN_BIT])
        |=> (r.state == bbt_pkg::BBT_RUNNING) && (r.remain == $past({r.tmr_hi, r.tmr_lo}));
    endproperty
    a_start: assert property (p_start) else $error("timer did not start on string request"); // R01

    property p_expire;
        @(posedge clk_sys) disable iff (!rst_n)
        (r.state == bbt_pkg::BBT_RUNNING && r.remain == 16'h0000) |=> !func_connect;
    endproperty
    a_expire: assert property (p_expire) else $error("no detach at timeout"); // R02

    property p_tick;
        @(posedge clk_sys) disable iff (!rst_n)
        (r.state == bbt_pkg::BBT_RUNNING && $past(r.state) == bbt_pkg::BBT_RUNNING
         && $changed(r.remain)) |-> $past(r.tick) == 24'(TICK_CYCLES - 1);
    endproperty
    a_tick: assert property (p_tick) else $error("count step not one tick"); // R03

    property p_dec;
        @(posedge clk_sys) disable iff (!rst_n)
        (r.state == bbt_pkg::BBT_RUNNING && $past(r.state) == bbt_pkg::BBT_RUNNING
         && $changed(r.remain)) |-> r.remain == $past(r.remain) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("count did not drop by one"); // R03

    property p_default;
        @(posedge clk_sys) $rose(rst_n) |->
            {r.tmr_hi, r.tmr_lo} == {bbt_pkg::TMR_HI_RST, bbt_pkg::TMR_LO_RST};
    endproperty
    a_default: assert property (p_default) else $error("timeout default wrong"); // R04

    property p_ack;
        @(posedge clk_sys) disable iff (!rst_n)
        (alt_string_req && billboard_mode && func_connect) |=> alt_string_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("string request not answered"); // R07

    property p_reattach;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(func_connect) |-> !billboard_mode;
    endproperty
    a_reattach: assert property (p_reattach) else $error("reconnect still billboard"); // R08

    property p_wr_desc;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && desc_hit) |=> desc[$past(desc_off[5:0])] == $past(reg_wdata);
    endproperty
    a_wr_desc: assert property (p_wr_desc) else $error("descriptor write lost"); // R05

    property p_vendor_stays;
        @(posedge clk_sys) disable iff (!rst_n)
        (r.state == bbt_pkg::BBT_VENDOR) |=> (r.state == bbt_pkg::BBT_VENDOR) && func_connect;
    endproperty
    a_vendor_stays: assert property (p_vendor_stays) else $error("vendor state left"); // R08

    c_start: cover property (@(posedge clk_sys) r.state == bbt_pkg::BBT_RUNNING);
    c_detach: cover property (@(posedge clk_sys) $fell(func_connect));
    c_vendor: cover property (@(posedge clk_sys) r.state == bbt_pkg::BBT_VENDOR);
    c_ack: cover property (@(posedge clk_sys) alt_string_ack);
endmodule // bbt_top
`default_nettype wire

// ==== verif/bbt_host.sv ====
// Host model that asks the internal function for its alternate-mode string.
`timescale 1ns/10ps
`default_nettype none
module bbt_host (
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic alt_string_req,
    input wire logic alt_string_ack,
    output logic [7:0] ack_count
);
    initial alt_string_req = 1'b0;
    // The pulse is one cycle, so a slow host simply calls this less often.
    task automatic request();
        @(posedge clk_sys);
        alt_string_req <= 1'b1;
        @(posedge clk_sys);
        alt_string_req <= 1'b0;
    endtask
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_count <= 8'h00;
        end else if (alt_string_ack) begin
            ack_count <= ack_count + 8'h01;
        end
    end
endmodule // bbt_host
`default_nettype wire

// ==== verif/tb_billboard_detach_timer_b.sv ====
// Self-checking bench for the Billboard detach timer B block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_billboard_detach_timer_b;
    localparam int TICK = 4;
    localparam int DET = 3;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, ack_count;
    logic alt_string_req, alt_string_ack, func_connect, billboard_mode;
    int miscompares = 0;
    int n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    bbt_top #(.TICK_CYCLES(TICK), .DETACH_CYCLES(DET)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .alt_string_req(alt_string_req),
        .alt_string_ack(alt_string_ack), .func_connect(func_connect),
        .billboard_mode(billboard_mode));
    bbt_host host (.clk_sys(clk_sys), .rst_n(rst_n), .alt_string_req(alt_string_req),
        .alt_string_ack(alt_string_ack), .ack_count(ack_count));
    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wait_conn(input logic v, output int n);
        n = 0;
        while (func_connect !== v && n < 2000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 2000) begin
            miscompares++;
            results();
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_defaults();
        `CHK(func_connect, 1'b1)
        `CHK(billboard_mode, 1'b1)
        rd(bbt_pkg::ADDR_TMR_LO, 8'hd0);
        rd(bbt_pkg::ADDR_TMR_HI, 8'h07);
        rd(bbt_pkg::ADDR_CTRL, 8'h01);
        rd(bbt_pkg::ADDR_STAT, 8'h02);
        rd(16'h4143, 8'h01);
        rd(16'h4144, 8'h01);
        rd(16'h4145, 8'h00);
        rd(16'h4147, 8'h80);
        rd(16'h4150, 8'h00);
        rd(16'h4168, 8'h10);
        rd(16'h4169, 8'h01);
        rd(16'h416c, 8'h00);
        rd(16'h416d, 8'hff);
        rd(16'h4200, 8'h00);
        $display("test defaults done");
    endtask
    task automatic t_config();
        wr(bbt_pkg::ADDR_TMR_HI, 8'h5a);
        rd(bbt_pkg::ADDR_TMR_HI, 8'h5a);
        wr(16'h4160, 8'ha5);
        rd(16'h4160, 8'ha5);
        wr(bbt_pkg::ADDR_STAT, 8'hff);
        rd(bbt_pkg::ADDR_STAT, 8'h02);
        $display("test config done");
    endtask
    // Only the high byte is set, so a wrong byte weight shows as a wrong delay.
    task automatic t_timer();
        int n;
        wr(bbt_pkg::ADDR_TMR_HI, 8'h01);
        wr(bbt_pkg::ADDR_TMR_LO, 8'h00);
        host.request();
        #1;
        `CHK(alt_string_ack, 1'b1)
        rd(bbt_pkg::ADDR_STAT, 8'h03);
        host.request();
        wait_conn(1'b0, n);
        `CHK((n + 4 >= 256 * TICK - 1) && (n + 4 <= 256 * TICK + 3), 1'b1)
        `CHK(ack_count, 8'h02)
        wait_conn(1'b1, n);
        `CHK((n >= DET - 1) && (n <= DET + 1), 1'b1)
        `CHK(billboard_mode, 1'b0)
        rd(bbt_pkg::ADDR_STAT, 8'h00);
        host.request();
        #1;
        `CHK(alt_string_ack, 1'b0)
        $display("test timer done");
    endtask
    // A fresh reset brings back the Billboard function, so the enable bit and the low byte
    // weight can be checked on a second timeout.
    task automatic t_enable();
        int n;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        `CHK(func_connect, 1'b1)
        `CHK(billboard_mode, 1'b1)
        rd(bbt_pkg::ADDR_TMR_HI, 8'h07);
        wr(bbt_pkg::ADDR_CTRL, 8'h00);
        wr(bbt_pkg::ADDR_TMR_HI, 8'h00);
        wr(bbt_pkg::ADDR_TMR_LO, 8'h03);
        host.request();
        #1;
        `CHK(alt_string_ack, 1'b1)
        rd(bbt_pkg::ADDR_STAT, 8'h02);
        wr(bbt_pkg::ADDR_CTRL, 8'h01);
        host.request();
        wait_conn(1'b0, n);
        `CHK(n, 3 * TICK + 1)
        `CHK(ack_count, 8'h02)
        wait_conn(1'b1, n);
        `CHK(n, DET)
        `CHK(billboard_mode, 1'b0)
        rd(bbt_pkg::ADDR_STAT, 8'h00);
        $display("test enable done");
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_defaults();
        t_config();
        t_timer();
        t_enable();
        results();
    end
endmodule // tb_billboard_detach_timer_b
`default_nettype wire
